// File: design/ppeikw_top.sv
// Pin logic for three byte-wide ports, two external interrupts and a keypad wake source.
// Assumes clk is the CPU clock, pins and interrupt inputs are asynchronous, and the
// register port and CPU interrupt signals are synchronous to clk.
//
// Summary of operation
// - Trigger select 0: low pin sample raises request.
// - Trigger select 1: high then low sample sets flag.
// - Interrupt pins sampled once per machine cycle.
// - Edge flag cleared when CPU vectors to it.
// - Level mode flag tracks sampled pin level.
// - Enabled external interrupt wakes sleeping CPU.
// - Two mode bits choose one of four modes.
// - Quasi mode: very weak pull-up when latch 1.
// - Quasi mode: weak pull-up when latch and pin 1.
// - Quasi mode: latch rise gives two-clock strong pull-up.
// - Open drain: no pull-ups, drive low on latch 0.
// - Push-pull: strong high on latch 1, else low.
// - Two fixed open-drain pins, one conditional input pin.
// - Crystal option disables both oscillator shared pins.
// - Reset level from config; quasi mode by default.
// - Per-port Schmitt select; fixed open-drain and input pins always Schmitt.
// - Key enable bits pick any port 0 pins.
// - Enabled low port 0 pin sets key flag.
// - Key flag clears only by software.
// - Enabled key interrupt wakes from Idle or Power Down.
// - Machine cycle is 6 clocks, or 12 when halved.
`timescale 1ns/1ns
`default_nettype none
module ppeikw_top
  import ppeikw_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire ppeikw_req_t       req,
  output logic [DW-1:0]          rdata,
  input  wire logic [7:0]        user_config_word,
  input  wire ppeikw_cpu_t       cpu,
  input  wire logic [NPIN-1:0]   pin_in,
  input  wire logic [1:0]        ext_irq_pin,
  output ppeikw_pad_t            pad,
  output logic [1:0]             ext_irq_request_flag,
  output logic                   key_event_flag,
  output logic                   wake
);

  ppeikw_state_t st_reg;
  ppeikw_state_t st_next;

  logic [NPIN-1:0] pin_s;
  logic [1:0]      irq_s;
  logic [3:0]      mc_last;
  logic            mc_strobe;
  logic [1:0]      md;
  logic            fixed_od;
  logic            dead;
  logic            rise_now;
  logic [1:0]      edge_hit;
  logic            key_hit;
  logic [NPIN-1:0] pin_read;

  assign pin_s     = st_reg.sync2[NPIN-1:0];
  assign irq_s     = st_reg.sync2[NPIN+1:NPIN];
  assign mc_last   = st_reg.halve ? MC_LAST_SLOW : MC_LAST_FAST;
  assign mc_strobe = st_reg.cfg_loaded && (st_reg.mc_cnt == mc_last);

  always_comb begin
    st_next  = st_reg;
    md       = MD_QB;
    fixed_od = 1'b0;
    dead     = 1'b0;
    rise_now = 1'b0;
    edge_hit = 2'h0;
    key_hit  = 1'b0;
    pin_read = pin_s;

    // Two-stage synchroniser for all pin inputs.
    st_next.sync1 = {ext_irq_pin, pin_in};
    st_next.sync2 = st_reg.sync1;

    // Configuration straps are taken once after reset release.
    if (!st_reg.cfg_loaded) begin
      st_next.cfg_loaded = 1'b1;
      st_next.halve      = user_config_word[UCW_HALVE];
      st_next.int_rst    = user_config_word[UCW_INT_RST];
      st_next.xtal       = user_config_word[UCW_XTAL];
      st_next.latch      = {NPIN{user_config_word[UCW_RST_HIGH]}};
    end

    // Machine cycle counter.
    if (!st_reg.cfg_loaded || mc_strobe) begin
      st_next.mc_cnt = 4'h0;
    end else begin
      st_next.mc_cnt = st_reg.mc_cnt + 4'h1;
    end

    // External interrupt sampling and flags.
    for (int i = 0; i < 2; i++) begin
      edge_hit[i] = mc_strobe && st_reg.trig[i] && st_reg.samp[i] && !irq_s[i];
      if (mc_strobe) begin
        st_next.samp[i] = irq_s[i];
      end
      if (!st_reg.trig[i]) begin
        if (mc_strobe) begin
          st_next.flag[i] = !irq_s[i];
        end
      end else if (edge_hit[i]) begin
        st_next.flag[i] = 1'b1;
      end else if (cpu.ack[i]) begin
        st_next.flag[i] = 1'b0;
      end
    end

    // Keypad flag: set wins over a software clear.
    key_hit = |(st_reg.key_pin_en & ~pin_s[7:0]);
    if (key_hit) begin
      st_next.key_flag = 1'b1;
    end else if (req.wr && req.addr == A_AUX1 && !req.wdata[AUX_KEYF]) begin
      st_next.key_flag = 1'b0;
    end

    // Register writes.
    if (req.wr && st_reg.cfg_loaded) begin
      for (int p = 0; p < NPORT; p++) begin
        if (req.addr == A_LATCH0 + 4'(p)) begin
          st_next.latch[p*8 +: 8] = req.wdata;
        end
        if (req.addr == A_MODE_A0 + 4'(2*p)) begin
          st_next.mode_a[p*8 +: 8] = req.wdata;
        end
        if (req.addr == A_MODE_B0 + 4'(2*p)) begin
          st_next.mode_b[p*8 +: 8] = req.wdata;
        end
      end
      if (req.addr == A_TCTRL) begin
        st_next.trig = {req.wdata[TC_TRIG1], req.wdata[TC_TRIG0]};
      end
      if (req.addr == A_P2MODE1) begin
        st_next.schm_sel = req.wdata[NPORT-1:0];
      end
      if (req.addr == A_KEYEN) begin
        st_next.key_pin_en = req.wdata;
      end
    end

    // Per-pin pad control.
    for (int k = 0; k < NPIN; k++) begin
      fixed_od = (k == PIN_OD_A) || (k == PIN_OD_B);
      dead     = (st_reg.xtal && (k == PIN_OSC_A || k == PIN_OSC_B)) ||
                 (!st_reg.int_rst && k == PIN_IN_F);
      md       = {st_reg.mode_a[k], st_reg.mode_b[k]};
      if (fixed_od) begin
        md = MD_OD;
      end
      if (k == PIN_IN_F) begin
        md = MD_IN;
      end
      rise_now = st_next.latch[k] && !st_reg.latch[k] && md == MD_QB;
      st_next.rise_d[k] = rise_now;
      pin_read[k] = pin_s[k] && !dead;
      st_next.pad.pu_vweak[k]  = !dead && md == MD_QB && st_reg.latch[k];
      st_next.pad.pu_weak[k]   = !dead && md == MD_QB && st_reg.latch[k] && pin_s[k];
      st_next.pad.pu_strong[k] = !dead && md == MD_QB && (rise_now || st_reg.rise_d[k]);
      st_next.pad.out_val[k]   = !dead && ((md == MD_PP && st_reg.latch[k]) ||
                                 st_next.pad.pu_strong[k]);
      st_next.pad.out_oe[k]    = !dead && md != MD_IN &&
                                 (!st_reg.latch[k] || md == MD_PP ||
                                 st_next.pad.pu_strong[k]);
      st_next.pad.schmitt[k]   = fixed_od || k == PIN_IN_F || st_reg.schm_sel[k/8];
    end

    // Wake request to the power control logic.
    st_next.wake = cpu.asleep && (|(st_reg.flag & cpu.ext_en) ||
                   (st_reg.key_flag && cpu.key_en));

    // Read data, one cycle after the strobe.
    st_next.rdata = '0;
    if (req.rd) begin
      for (int p = 0; p < NPORT; p++) begin
        if (req.addr == A_LATCH0 + 4'(p)) begin
          st_next.rdata = st_reg.latch[p*8 +: 8];
        end
        if (req.addr == A_MODE_A0 + 4'(2*p)) begin
          st_next.rdata = st_reg.mode_a[p*8 +: 8];
        end
        if (req.addr == A_MODE_B0 + 4'(2*p)) begin
          st_next.rdata = st_reg.mode_b[p*8 +: 8];
        end
        if (req.addr == A_PIN0 + 4'(p)) begin
          st_next.rdata = pin_read[p*8 +: 8];
        end
      end
      if (req.addr == A_TCTRL) begin
        st_next.rdata[TC_TRIG0] = st_reg.trig[0];
        st_next.rdata[TC_FLAG0] = st_reg.flag[0];
        st_next.rdata[TC_TRIG1] = st_reg.trig[1];
        st_next.rdata[TC_FLAG1] = st_reg.flag[1];
      end
      if (req.addr == A_P2MODE1) begin
        st_next.rdata[NPORT-1:0] = st_reg.schm_sel;
      end
      if (req.addr == A_KEYEN) begin
        st_next.rdata = st_reg.key_pin_en;
      end
      if (req.addr == A_AUX1) begin
        st_next.rdata[AUX_KEYF] = st_reg.key_flag;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata                = st_reg.rdata;
  assign pad                  = st_reg.pad;
  assign ext_irq_request_flag = st_reg.flag;
  assign key_event_flag       = st_reg.key_flag;
  assign wake                 = st_reg.wake;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_gap6;
    !mc_strobe [*5] ##1 mc_strobe;
  endsequence

  sequence s_strong2;
    pad.pu_strong[0] [*2] ##1 !pad.pu_strong[0];
  endsequence

  property p_mc_fast;
    mc_strobe && !st_reg.halve |=> s_gap6;
  endproperty
  a_mc_fast: assert property (p_mc_fast) else $error("Machine cycle not 6 clocks.");

  property p_mc_slow;
    mc_strobe && st_reg.halve |-> ##12 mc_strobe;
  endproperty
  a_mc_slow: assert property (p_mc_slow) else $error("Halved machine cycle not 12 clocks.");

  property p_level_follow;
    mc_strobe && !st_reg.trig[0] |=> ext_irq_request_flag[0] == !$past(irq_s[0]);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("Level flag does not track pin.");

  property p_level_hold;
    !mc_strobe && !st_reg.trig[1] && !$past(req.wr) |=> $stable(ext_irq_request_flag[1]);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("Level flag moved between samples.");

  property p_edge_set;
    mc_strobe && st_reg.trig[0] && st_reg.samp[0] && !irq_s[0] |=> ext_irq_request_flag[0];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("Falling edge did not set flag.");

  property p_edge_ack;
    st_reg.trig[0] && cpu.ack[0] && !edge_hit[0] |=> !ext_irq_request_flag[0];
  endproperty
  a_edge_ack: assert property (p_edge_ack) else $error("Vectoring did not clear edge flag.");

  property p_key_set;
    |(st_reg.key_pin_en & ~pin_s[7:0]) |=> key_event_flag;
  endproperty
  a_key_set: assert property (p_key_set) else $error("Enabled low key pin did not set flag.");

  property p_key_sticky;
    key_event_flag && !(req.wr && req.addr == A_AUX1) |=> key_event_flag;
  endproperty
  a_key_sticky: assert property (p_key_sticky) else $error("Key flag cleared without software.");

  property p_strong;
    st_reg.cfg_loaded && req.wr && req.addr == A_LATCH0 && req.wdata[0] && !st_reg.latch[0] &&
      !st_reg.mode_a[0] && !st_reg.mode_b[0] |=> s_strong2;
  endproperty
  a_strong: assert property (p_strong) else $error("Strong pull-up not two clocks.");

  property p_od_nopull;
    st_reg.cfg_loaded |=> !pad.pu_vweak[PIN_OD_A] && !pad.pu_weak[PIN_OD_B] && !pad.out_val[PIN_OD_A];
  endproperty
  a_od_nopull: assert property (p_od_nopull) else $error("Open-drain pin has a pull-up.");

  property p_wake;
    cpu.asleep && st_reg.key_flag && cpu.key_en |=> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("Key event did not wake CPU.");

  property p_wake_ext;
    cpu.asleep && |(st_reg.flag & cpu.ext_en) |=> wake;
  endproperty
  a_wake_ext: assert property (p_wake_ext) else $error("External request did not wake CPU.");

  property p_edge_hold;
    st_reg.trig[0] && !edge_hit[0] && !cpu.ack[0] |=> $stable(ext_irq_request_flag[0]);
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("Edge flag moved without edge or vector.");

  property p_samp_hold;
    !mc_strobe |=> $stable(st_reg.samp);
  endproperty
  a_samp_hold: assert property (p_samp_hold) else $error("Interrupt pin sampled off the strobe.");

  property p_level_follow1;
    mc_strobe && !st_reg.trig[1] |=> ext_irq_request_flag[1] == !$past(irq_s[1]);
  endproperty
  a_level_follow1: assert property (p_level_follow1) else $error("Level flag one does not track pin.");

  property p_push_pull;
    !st_reg.mode_a[1] && st_reg.mode_b[1] |=> pad.out_oe[1] && pad.out_val[1] == $past(st_reg.latch[1]);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("Push-pull pin does not follow latch.");

  property p_input_only;
    st_reg.mode_a[2] && !st_reg.mode_b[2] |=>
      !pad.out_oe[2] && !(pad.pu_vweak[2] || pad.pu_weak[2] || pad.pu_strong[2]);
  endproperty
  a_input_only: assert property (p_input_only) else $error("Input-only pin drives or pulls.");

  property p_open_drain;
    st_reg.mode_a[3] && st_reg.mode_b[3] |=>
      pad.out_oe[3] == !$past(st_reg.latch[3]) && !pad.out_val[3] && !pad.pu_vweak[3];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Open-drain pin drive is wrong.");

  property p_vweak;
    !st_reg.mode_a[0] && !st_reg.mode_b[0] |=> pad.pu_vweak[0] == $past(st_reg.latch[0]);
  endproperty
  a_vweak: assert property (p_vweak) else $error("Very weak pull-up does not follow latch.");

  property p_weak;
    !st_reg.mode_a[0] && !st_reg.mode_b[0] |=> pad.pu_weak[0] == ($past(st_reg.latch[0]) && $past(pin_s[0]));
  endproperty
  a_weak: assert property (p_weak) else $error("Weak pull-up does not follow latch and pin.");

  property p_strong_qb;
    st_reg.mode_a[0] || st_reg.mode_b[0] |=> !pad.pu_strong[0];
  endproperty
  a_strong_qb: assert property (p_strong_qb) else $error("Strong pull-up outside quasi mode.");

  property p_osc_dead;
    st_reg.xtal |=> !pad.out_oe[PIN_OSC_A] && !pad.out_oe[PIN_OSC_B] &&
      !pad.pu_vweak[PIN_OSC_A] && !pad.pu_vweak[PIN_OSC_B];
  endproperty
  a_osc_dead: assert property (p_osc_dead) else $error("Oscillator pin still drives.");

  property p_osc_read;
    st_reg.xtal && req.rd && req.addr == A_PIN0 + 4'h2 |=> rdata[1:0] == 2'h0;
  endproperty
  a_osc_read: assert property (p_osc_read) else $error("Oscillator pin input not blocked.");

  property p_schm_port;
    st_reg.cfg_loaded |=> pad.schmitt[7:0] == {8{$past(st_reg.schm_sel[0])}};
  endproperty
  a_schm_port: assert property (p_schm_port) else $error("Port Schmitt select not applied.");

  property p_key_quiet;
    !key_hit && !key_event_flag |=> !key_event_flag;
  endproperty
  a_key_quiet: assert property (p_key_quiet) else $error("Key flag set without enabled low pin.");

  property p_rst_level;
    $rose(st_reg.cfg_loaded) |-> st_reg.latch == {NPIN{$past(user_config_word[UCW_RST_HIGH])}} &&
      st_reg.mode_a == '0 && st_reg.mode_b == '0;
  endproperty
  a_rst_level: assert property (p_rst_level) else $error("Reset level or mode not from strap.");

  property p_key_clear;
    key_event_flag && !key_hit && req.wr && req.addr == A_AUX1 && !req.wdata[AUX_KEYF] |=> !key_event_flag;
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("Software clear of key flag ignored.");

endmodule
`default_nettype wire

// File: design/ppeikw_pkg.sv
// Shared constants and carrier types for the port pin, external interrupt and keypad wake block.
// Assumes a single CPU clock domain and a plain byte-wide register port.
package ppeikw_pkg;

  localparam int NPORT     = 3;
  localparam int NPIN      = 24;
  localparam int AW        = 4;
  localparam int DW        = 8;

  // Register indices on the register port.
  localparam logic [3:0] A_LATCH0  = 4'h0;
  localparam logic [3:0] A_MODE_A0 = 4'h3;
  localparam logic [3:0] A_MODE_B0 = 4'h4;
  localparam logic [3:0] A_TCTRL   = 4'h9;
  localparam logic [3:0] A_P2MODE1 = 4'hA;
  localparam logic [3:0] A_KEYEN   = 4'hB;
  localparam logic [3:0] A_AUX1    = 4'hC;
  localparam logic [3:0] A_PIN0    = 4'hD;

  // Field positions in the interrupt control register and, for AUX_KEYF, the AUX1 register.
  localparam int TC_TRIG0 = 0;
  localparam int TC_FLAG0 = 1;
  localparam int TC_TRIG1 = 2;
  localparam int TC_FLAG1 = 3;
  localparam int AUX_KEYF = 0;

  // Field positions in the user configuration word.
  localparam int UCW_RST_HIGH = 0;
  localparam int UCW_HALVE    = 1;
  localparam int UCW_INT_RST  = 2;
  localparam int UCW_XTAL     = 3;

  // Fixed-function pin indices (port * 8 + bit).
  localparam int PIN_OD_A  = 10;
  localparam int PIN_OD_B  = 11;
  localparam int PIN_IN_F  = 13;
  localparam int PIN_OSC_A = 16;
  localparam int PIN_OSC_B = 17;

  // Last machine cycle counter values; a machine cycle is one more than this in CPU clocks.
  localparam logic [3:0] MC_LAST_FAST = 4'h5;
  localparam logic [3:0] MC_LAST_SLOW = 4'hB;

  // Output mode encodings {mode_a, mode_b}.
  localparam logic [1:0] MD_QB = 2'h0;
  localparam logic [1:0] MD_PP = 2'h1;
  localparam logic [1:0] MD_IN = 2'h2;
  localparam logic [1:0] MD_OD = 2'h3;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } ppeikw_req_t;

  typedef struct packed {
    logic [1:0] ack;
    logic [1:0] ext_en;
    logic       key_en;
    logic       asleep;
  } ppeikw_cpu_t;

  typedef struct packed {
    logic [NPIN-1:0] out_val;
    logic [NPIN-1:0] out_oe;
    logic [NPIN-1:0] pu_vweak;
    logic [NPIN-1:0] pu_weak;
    logic [NPIN-1:0] pu_strong;
    logic [NPIN-1:0] schmitt;
  } ppeikw_pad_t;

  typedef struct packed {
    logic            cfg_loaded;
    logic            halve;
    logic            int_rst;
    logic            xtal;
    logic [NPIN-1:0] latch;
    logic [NPIN-1:0] mode_a;
    logic [NPIN-1:0] mode_b;
    logic [NPORT-1:0] schm_sel;
    logic [1:0]      trig;
    logic [1:0]      flag;
    logic [1:0]      samp;
    logic [7:0]      key_pin_en;
    logic            key_flag;
    logic [3:0]      mc_cnt;
    logic [NPIN-1:0] rise_d;
    logic [NPIN+1:0] sync1;
    logic [NPIN+1:0] sync2;
    ppeikw_pad_t     pad;
    logic [DW-1:0]   rdata;
    logic            wake;
  } ppeikw_state_t;

endpackage

// File: sim/ppeikw_pins.sv
// Far-side model of the pins: keypad switches and interrupt sources.
// Assumes the pad controls of the port block and one clock that paces floating pins.
`timescale 1ns/1ns
`default_nettype none
module ppeikw_pins
  import ppeikw_pkg::*;
(
  input  wire logic            clk,
  input  wire ppeikw_pad_t     pad,
  input  wire logic [NPIN-1:0] key_low,
  input  wire logic [1:0]      irq_low,
  output logic [NPIN-1:0]      pin_in,
  output logic [1:0]           ext_irq_pin
);
  logic [NPIN-1:0] flt;
  // A pin that nobody drives or pulls changes level every cycle.
  initial flt = '0;
  always @(posedge clk) flt <= ~flt;
  // A driven level wins, then a closed switch, then any pull-up.
  assign pin_in = (pad.out_oe & pad.out_val) |
                  (~pad.out_oe & ~key_low & (pad.pu_vweak | pad.pu_weak | pad.pu_strong | flt));
  assign ext_irq_pin = ~irq_low;
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the port pin, external interrupt and keypad block.
// Assumes the pin model on the far side; straps change only while reset is held.
`timescale 1ns/1ns
`default_nettype none
module tb
  import ppeikw_pkg::*;
;
  logic            clk;
  logic            rst_n;
  ppeikw_req_t     req;
  logic [DW-1:0]   rdata;
  logic [7:0]      ucw;
  ppeikw_cpu_t     cpu;
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] key_low;
  logic [1:0]      irq_low;
  logic [1:0]      ext_irq_pin;
  ppeikw_pad_t     pad;
  logic [1:0]      ext_irq_request_flag;
  logic            key_event_flag;
  logic            wake;
  logic [DW-1:0]   d;
  int              c;
  int              failures;
  int              tests_run;

  ppeikw_top u_ppeikw_top (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .user_config_word(ucw),
    .cpu(cpu), .pin_in(pin_in), .ext_irq_pin(ext_irq_pin), .pad(pad),
    .ext_irq_request_flag(ext_irq_request_flag), .key_event_flag(key_event_flag), .wake(wake));
  ppeikw_pins u_ppeikw_pins (.clk(clk), .pad(pad), .key_low(key_low), .irq_low(irq_low),
    .pin_in(pin_in), .ext_irq_pin(ext_irq_pin));

  always #2 clk = ~clk;

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
  endtask

  task rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
    #1 v = rdata;
  endtask

  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task rst(input logic [7:0] s);
    @(posedge clk) rst_n <= 1'b0;
    ucw <= s;
    tick(20);
    @(posedge clk) rst_n <= 1'b1;
    tick(6);
  endtask

  // Measures how long a level request stands after the pin returns high at once.
  task per(input int n, input int e);
    int k;
    k = 0;
    @(posedge clk) irq_low[n] <= 1'b1;
    while (ext_irq_request_flag[n] !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    @(posedge clk) irq_low[n] <= 1'b0;
    k = 1;
    while (ext_irq_request_flag[n] === 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    chk("level_period", 24'(e), 24'(k));
  endtask

  task final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #40000;
    failures++;
    final_report;
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    ucw = 8'h05;
    cpu = '0;
    key_low = '0;
    irq_low = '0;
    failures = 0;
    tests_run = 0;
    rst(8'h05);
    rd(A_LATCH0, d);
    chk("latch0_rst", 24'hFF, 24'(d));
    rd(A_MODE_A0, d);
    chk("mode_a0_rst", 24'h00, 24'(d));
    chk("vweak_p0", 24'hFF, 24'(pad.pu_vweak[7:0]));
    chk("weak_p0", 24'hFF, 24'(pad.pu_weak[7:0]));
    @(posedge clk) key_low <= 24'h000001;
    tick(5);
    chk("weak_pressed", 24'hFE, 24'(pad.pu_weak[7:0]));
    chk("vweak_pressed", 24'hFF, 24'(pad.pu_vweak[7:0]));
    @(posedge clk) key_low <= '0;
    #1 chk("schmitt_fixed", 24'h002C00, pad.schmitt);
    wr(A_P2MODE1, 8'h01);
    tick(2);
    chk("schmitt_p0", 24'h002CFF, pad.schmitt);
    chk("od_fixed_hi", 24'h0, 24'({pad.out_oe[10], pad.pu_weak[10], pad.pu_vweak[11]}));
    wr(A_LATCH0 + 4'h1, 8'h00);
    tick(2);
    chk("od_fixed_lo", 24'hC, 24'({pad.out_oe[11:10], pad.out_oe[13], pad.out_val[10]}));
    wr(A_MODE_A0, 8'h0C);
    wr(A_MODE_B0, 8'h0A);
    tick(2);
    chk("modes_hi", 24'h0C, 24'({pad.out_oe[3:1], pad.out_val[1], pad.pu_vweak[3:2]}));
    wr(A_LATCH0, 8'hF1);
    tick(2);
    chk("modes_lo", 24'h28, 24'({pad.out_oe[3:1], pad.out_val[3:1]}));
    wr(A_LATCH0, 8'hF0);
    wr(A_LATCH0, 8'hF1);
    c = 0;
    repeat (8) begin
      #1;
      if (pad.pu_strong[0] === 1'b1) c++;
      @(posedge clk);
    end
    chk("strong_len", 24'h2, 24'(c));
    wr(A_TCTRL, 8'h01);
    tick(14);
    @(posedge clk) irq_low[0] <= 1'b1;
    c = 0;
    while (ext_irq_request_flag[0] !== 1'b1 && c < 20) begin
      tick(1);
      c++;
    end
    chk("edge_latency", 24'h1, 24'(c >= 3 && c <= 8));
    @(posedge clk) cpu <= '{ack: 2'h0, ext_en: 2'h1, key_en: 1'b0, asleep: 1'b1};
    tick(3);
    chk("wake_ext", 24'h1, 24'(wake));
    @(posedge clk) cpu.ack <= 2'h1;
    @(posedge clk) cpu.ack <= 2'h0;
    #1 chk("edge_ack", 24'h0, 24'(ext_irq_request_flag[0]));
    tick(14);
    chk("edge_once", 24'h0, 24'(ext_irq_request_flag[0]));
    rd(A_TCTRL, d);
    chk("tctrl", 24'h01, 24'(d));
    @(posedge clk) irq_low[0] <= 1'b0;
    cpu <= '0;
    per(1, 6);
    wr(A_KEYEN, 8'h10);
    @(posedge clk) key_low <= 24'h000020;
    tick(6);
    chk("key_unselected", 24'h0, 24'(key_event_flag));
    @(posedge clk) key_low <= 24'h000030;
    tick(6);
    chk("key_set", 24'h1, 24'(key_event_flag));
    @(posedge clk) cpu <= '{ack: 2'h0, ext_en: 2'h0, key_en: 1'b1, asleep: 1'b1};
    key_low <= '0;
    tick(3);
    chk("wake_key", 24'h1, 24'(wake));
    rd(A_AUX1, d);
    chk("key_hold", 24'h1, 24'(d & 8'h01));
    wr(A_AUX1, 8'h00);
    tick(1);
    chk("key_clear", 24'h0, 24'(key_event_flag));
    @(posedge clk) cpu <= '0;
    rst(8'h0A);
    rd(A_LATCH0, d);
    chk("latch0_low", 24'h00, 24'(d));
    chk("dead_pins", 24'h10, 24'({pad.out_oe[18:16], pad.pu_vweak[16], pad.out_oe[13]}));
    wr(A_LATCH0 + 4'h2, 8'hFF);
    tick(4);
    rd(A_PIN0 + 4'h2, d);
    chk("osc_read", 24'h04, 24'(d & 8'h07));
    per(1, 12);
    final_report;
  end
endmodule
`default_nettype wire
